// [design/tlos_pkg.sv]
// Shared constants, types and helpers for the timed logic operator set
package tlos_pkg;
	localparam int          CLK_PERIOD_NS = 4;                            // System clock period
	localparam int          MS_PERIOD_NS  = 1000000;                      // One millisecond in ns
	localparam int          TICK_CYCLES   = MS_PERIOD_NS / CLK_PERIOD_NS; // Clocks per ms tick
	localparam int          CHANNELS      = 8;                            // Channels per operator
	localparam int          MS_W          = 13;                           // Width of a ms setting
	localparam logic [12:0] MS_MAX        = 13'h1770;                     // 6000 ms ceiling
	localparam int          ADDR_W        = 8;                            // Register address width
	localparam int          DATA_W        = 32;                           // Register data width

	// Register byte offsets
	localparam logic [7:0] REG_MODE      = 8'h00; // Pulse generator mode
	localparam logic [7:0] REG_PULSE_ON  = 8'h04; // Pulse high-phase time, ms
	localparam logic [7:0] REG_PULSE_OFF = 8'h08; // Pulse low-phase time, ms
	localparam logic [7:0] REG_DEB_ON    = 8'h0c; // Filter assert delay, ms
	localparam logic [7:0] REG_DEB_OFF   = 8'h10; // Filter release delay, ms
	localparam logic [7:0] REG_STATE_A   = 8'h14; // Pulse, filter, latch-all, global outputs
	localparam logic [7:0] REG_STATE_B   = 8'h18; // Set/clear latch and splitter outputs

	// Field positions in the status words
	localparam int STA_PULSE_LSB  = 0;  // Pulse outputs in state A
	localparam int STA_DEB_LSB    = 8;  // Filter outputs in state A
	localparam int STA_ALL_LSB    = 16; // Latch-all outputs in state A
	localparam int STA_GLOB_LSB   = 24; // Global-toggle outputs in state A
	localparam int STB_SC_LSB     = 0;  // Set/clear latch outputs in state B
	localparam int STB_SPLIT_LSB  = 16; // Splitter outputs in state B
	localparam int MODE_LSB       = 0;  // Mode field position

	// Reset values
	localparam logic [1:0]  MODE_RESET = 2'h0;  // Standard mode
	localparam logic [12:0] MS_RESET   = 13'h0; // Zero delay

	// Pulse generator modes
	typedef enum logic [1:0] {
		TLOS_MODE_STANDARD = 2'h0,
		TLOS_MODE_SINGLE   = 2'h1,
		TLOS_MODE_FORCED   = 2'h2
	} tlos_mode_type;

	// Pulse generator channel states
	typedef enum logic [2:0] {
		TLOS_PG_IDLE = 3'h1,
		TLOS_PG_HIGH = 3'h2,
		TLOS_PG_LOW  = 3'h4
	} tlos_pg_state_type;

	// Limit a written ms value to the 6000 ms ceiling
	function automatic logic [12:0] clamp_ms(input logic [31:0] value);
		if (value > {19'h0, MS_MAX}) begin
			return MS_MAX;
		end
		return value[12:0];
	endfunction
endpackage

// [design/tlos_timer_if.sv]
// Control bundle between an operator channel and its millisecond timer
`timescale 1ns/100ps
`default_nettype none
interface tlos_timer_if;
	logic        start; // Load the limit and run
	logic        stop;  // Abandon a running count
	logic [12:0] limit; // Delay in ms
	logic        done;  // Delay elapsed, one cycle

	modport ctl (output start, output stop, output limit, input done);
	modport tmr (input start, input stop, input limit, output done);
endinterface
`default_nettype wire

// [design/tlos_ms_timer.sv]
// Millisecond down-counter driven by the shared ms tick
`timescale 1ns/100ps
`default_nettype none
module tlos_ms_timer (
	input  wire logic   clk_in,
	input  wire logic   reset_n_in,
	input  wire logic   ce_in,
	input  wire logic   tick_in,
	tlos_timer_if.tmr   tmr
);
	logic [12:0] count;   // Remaining ms
	logic        running; // Count in progress

	// Zero remaining while running ends the delay
	assign tmr.done = running && (count == 13'h0);

	// Load, cancel and count down on each tick
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			running <= 1'b0;
			count   <= 13'h0;
		end else if (ce_in) begin
			if (tmr.start) begin
				running <= 1'b1;
				count   <= tmr.limit;
			end else if (tmr.stop || tmr.done) begin
				running <= 1'b0;
			end else if (running && tick_in) begin
				count <= count - 13'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [design/tlos_top.sv]
// Timed logic operator set: pulse, filter, latches and splitter
`timescale 1ns/100ps
`default_nettype none
module tlos_top #(
	parameter int TICK_CYCLES = tlos_pkg::TICK_CYCLES // Clocks per ms tick
) (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic [7:0]  pulse_in,
	output logic      [7:0]  pulse_out,
	input  wire logic [7:0]  filter_in,
	output logic      [7:0]  filter_out,
	input  wire logic [7:0]  all_in,
	output logic      [7:0]  all_out,
	input  wire logic [7:0]  glob_in,
	input  wire logic        glob_toggle_in,
	output logic      [7:0]  glob_out,
	input  wire logic [7:0]  sc_in,
	input  wire logic        sc_set_in,
	input  wire logic        sc_clear_in,
	output logic      [7:0]  sc_out,
	input  wire logic [7:0]  split_in,
	output logic      [15:0] split_out
);
	localparam int N = tlos_pkg::CHANNELS; // Channel count

	logic [1:0]  mode_reg;      // Pulse generator mode
	logic [12:0] pulse_on_ms;   // High phase time
	logic [12:0] pulse_off_ms;  // Low phase time
	logic [12:0] deb_on_ms;     // Filter assert delay
	logic [12:0] deb_off_ms;    // Filter release delay
	logic [31:0] tick_count;    // Ms tick divider
	logic        ms_tick;       // One-cycle ms tick
	logic [7:0]  pulse_q;       // Previous pulse inputs
	logic [7:0]  filter_q;      // Previous filter inputs
	logic [7:0]  all_q;         // Previous latch-all inputs
	logic [7:0]  glob_q;        // Previous global-latch inputs
	logic        glob_toggle_q; // Previous global toggle input
	logic [7:0]  sc_q;          // Previous set/clear channel inputs
	logic        sc_set_q;      // Previous global set input
	logic        sc_clear_q;    // Previous global clear input
	logic [7:0]  glob_raised;   // Outputs raised by the global toggle
	logic        all_state;     // Shared latch-all level
	logic [7:0]  pulse_done;    // Completed pulses, pulse inputs
	logic [7:0]  pulse_rise;    // Rising edges, pulse inputs
	logic [7:0]  all_done;      // Completed pulses, latch-all
	logic [7:0]  glob_done;     // Completed pulses, global latch channels
	logic [7:0]  sc_done;       // Completed pulses, set/clear channels
	logic        glob_hit;      // Completed global toggle pulse
	logic        sc_set_hit;    // Completed global set pulse
	logic        sc_clear_hit;  // Completed global clear pulse

	// Completed pulse: input was high, now low
	function automatic logic [7:0] fell(input logic [7:0] now, input logic [7:0] was);
		return was & ~now;
	endfunction

	assign pulse_rise   = pulse_in & ~pulse_q;
	assign pulse_done   = fell(pulse_in, pulse_q);
	assign all_done     = fell(all_in, all_q);
	assign glob_done    = fell(glob_in, glob_q);
	assign sc_done      = fell(sc_in, sc_q);
	assign glob_hit     = glob_toggle_q && !glob_toggle_in;
	assign sc_set_hit   = sc_set_q && !sc_set_in;
	assign sc_clear_hit = sc_clear_q && !sc_clear_in;

	// Register writes; limits clamp at the ceiling
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_reg     <= tlos_pkg::MODE_RESET;
			pulse_on_ms  <= tlos_pkg::MS_RESET;
			pulse_off_ms <= tlos_pkg::MS_RESET;
			deb_on_ms    <= tlos_pkg::MS_RESET;
			deb_off_ms   <= tlos_pkg::MS_RESET;
		end else if (ce_in && reg_wr_in) begin
			unique case (reg_addr_in)
				tlos_pkg::REG_MODE: begin
					mode_reg <= reg_wdata_in[tlos_pkg::MODE_LSB +: 2];
				end
				tlos_pkg::REG_PULSE_ON: begin
					pulse_on_ms <= tlos_pkg::clamp_ms(reg_wdata_in);
				end
				tlos_pkg::REG_PULSE_OFF: begin
					pulse_off_ms <= tlos_pkg::clamp_ms(reg_wdata_in);
				end
				tlos_pkg::REG_DEB_ON: begin
					deb_on_ms <= tlos_pkg::clamp_ms(reg_wdata_in);
				end
				tlos_pkg::REG_DEB_OFF: begin
					deb_off_ms <= tlos_pkg::clamp_ms(reg_wdata_in);
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, data valid the following cycle
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 32'h0;
		end else if (ce_in) begin
			reg_rdata_out <= 32'h0;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					tlos_pkg::REG_MODE: begin
						reg_rdata_out <= {30'h0, mode_reg};
					end
					tlos_pkg::REG_PULSE_ON: begin
						reg_rdata_out <= {19'h0, pulse_on_ms};
					end
					tlos_pkg::REG_PULSE_OFF: begin
						reg_rdata_out <= {19'h0, pulse_off_ms};
					end
					tlos_pkg::REG_DEB_ON: begin
						reg_rdata_out <= {19'h0, deb_on_ms};
					end
					tlos_pkg::REG_DEB_OFF: begin
						reg_rdata_out <= {19'h0, deb_off_ms};
					end
					tlos_pkg::REG_STATE_A: begin
						reg_rdata_out <= {glob_out, all_out, filter_out, pulse_out};
					end
					tlos_pkg::REG_STATE_B: begin
						reg_rdata_out <= {split_out, 8'h0, sc_out};
					end
					default: begin // Unmapped reads stay zero
					end
				endcase
			end
		end
	end

	// Ms tick divider
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_count <= 32'h0;
			ms_tick    <= 1'b0;
		end else if (ce_in) begin
			if (tick_count == 32'(TICK_CYCLES - 1)) begin
				tick_count <= 32'h0;
				ms_tick    <= 1'b1;
			end else begin
				tick_count <= tick_count + 32'h1;
				ms_tick    <= 1'b0;
			end
		end
	end

	// Previous input levels for pulse detection
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pulse_q       <= 8'h0;
			filter_q      <= 8'h0;
			all_q         <= 8'h0;
			glob_q        <= 8'h0;
			glob_toggle_q <= 1'b0;
			sc_q          <= 8'h0;
			sc_set_q      <= 1'b0;
			sc_clear_q    <= 1'b0;
		end else if (ce_in) begin
			pulse_q       <= pulse_in;
			filter_q      <= filter_in;
			all_q         <= all_in;
			glob_q        <= glob_in;
			glob_toggle_q <= glob_toggle_in;
			sc_q          <= sc_in;
			sc_set_q      <= sc_set_in;
			sc_clear_q    <= sc_clear_in;
		end
	end

	// Per-channel pulse generators and edge-delay filters
	generate
		for (genvar i = 0; i < N; i++) begin : g_chan
			tlos_timer_if                pg_t ();  // Pulse generator timer
			tlos_timer_if                df_t ();  // Filter timer
			tlos_pkg::tlos_pg_state_type state;    // Generator state
			tlos_pkg::tlos_pg_state_type next_state; // Next generator state
			logic                        pending;  // Latched rise awaiting a cycle
			logic                        trigger;  // Start a new cycle

			tlos_ms_timer u_pg_timer (
				.clk_in     (clk_in),
				.reset_n_in (reset_n_in),
				.ce_in      (ce_in),
				.tick_in    (ms_tick),
				.tmr        (pg_t)
			);
			tlos_ms_timer u_df_timer (
				.clk_in     (clk_in),
				.reset_n_in (reset_n_in),
				.ce_in      (ce_in),
				.tick_in    (ms_tick),
				.tmr        (df_t)
			);

			// Mode decides what starts a cycle
			always_comb begin
				unique case (tlos_pkg::tlos_mode_type'(mode_reg))
					tlos_pkg::TLOS_MODE_FORCED: begin
						trigger = 1'b1;
					end
					tlos_pkg::TLOS_MODE_SINGLE: begin
						trigger = pending || pulse_rise[i];
					end
					default: begin
						trigger = pending || pulse_in[i];
					end
				endcase
			end

			// Idle, high phase, low phase
			always_comb begin
				next_state = state;
				pg_t.start = 1'b0;
				pg_t.stop  = 1'b0;
				pg_t.limit = pulse_on_ms;
				unique case (state)
					tlos_pkg::TLOS_PG_IDLE: begin
						if (trigger) begin
							next_state = tlos_pkg::TLOS_PG_HIGH;
							pg_t.start = 1'b1;
						end
					end
					tlos_pkg::TLOS_PG_HIGH: begin
						if (pg_t.done) begin
							next_state = tlos_pkg::TLOS_PG_LOW;
							pg_t.start = 1'b1;
							pg_t.limit = pulse_off_ms;
						end
					end
					tlos_pkg::TLOS_PG_LOW: begin
						if (pg_t.done) begin
							next_state = tlos_pkg::TLOS_PG_IDLE;
						end
					end
					default: begin
						next_state = tlos_pkg::TLOS_PG_IDLE;
					end
				endcase
			end

			// Generator state, latched rise and output
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					state        <= tlos_pkg::TLOS_PG_IDLE;
					pending      <= 1'b0;
					pulse_out[i] <= 1'b0;
				end else if (ce_in) begin
					state        <= next_state;
					pulse_out[i] <= (next_state == tlos_pkg::TLOS_PG_HIGH);
					if (state == tlos_pkg::TLOS_PG_IDLE && trigger) begin
						pending <= pending && pulse_rise[i]; // Fresh rise beside a used one stays
					end else if (pulse_rise[i]) begin
						pending <= 1'b1;
					end
				end
			end

			// Filter: time a change, cancel if it reverts
			always_comb begin
				df_t.start = 1'b0;
				df_t.stop  = 1'b0;
				df_t.limit = filter_in[i] ? deb_on_ms : deb_off_ms;
				if (filter_in[i] != filter_q[i]) begin
					if (filter_in[i] != filter_out[i]) begin
						df_t.start = 1'b1;
					end else begin
						df_t.stop = 1'b1;
					end
				end
			end

			// Filtered output follows once the delay ends
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					filter_out[i] <= 1'b0;
				end else if (ce_in && df_t.done && !df_t.stop) begin
					filter_out[i] <= filter_in[i];
				end
			end

			// Splitter pair: even copies, odd inverts
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					split_out[2*i +: 2] <= 2'h0;
				end else if (ce_in) begin
					split_out[2*i +: 2] <= {~split_in[i], split_in[i]};
				end
			end
		end
	endgenerate

	// Latch-all: any completed pulse flips every output
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			all_state <= 1'b0;
		end else if (ce_in && (|all_done)) begin
			all_state <= ~all_state;
		end
	end
	assign all_out = {N{all_state}};

	// Global-toggle latch; global input beats the channels
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			glob_out    <= 8'h0;
			glob_raised <= 8'h0;
		end else if (ce_in) begin
			if (glob_hit && !(&glob_out)) begin
				glob_out    <= 8'hff;
				glob_raised <= (glob_raised | ~glob_out);
			end else if (glob_hit) begin
				glob_out    <= glob_out & ~glob_raised;
				glob_raised <= 8'h0;
			end else begin
				glob_out    <= glob_out ^ glob_done;
				glob_raised <= glob_raised & ~glob_done;
			end
		end
	end

	// Set/clear latch; global clear beats set beats channels
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sc_out <= 8'h0;
		end else if (ce_in) begin
			if (sc_clear_hit) begin
				sc_out <= 8'h0;
			end else if (sc_set_hit) begin
				sc_out <= 8'hff;
			end else begin
				sc_out <= sc_out ^ sc_done;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/tlos_logic_src.sv]
// Far-side logic source that drives timed pulses onto operator inputs
`timescale 1ns/100ps
`default_nettype none
module tlos_logic_src #(
	parameter int W = 43 // Number of driven lines
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic         go_in,    // Start one pulse
	input  wire logic [W-1:0] mask_in,  // Lines to raise
	input  wire logic [15:0]  len_in,   // High time in cycles
	output logic              busy_out, // Pulse in progress
	output logic      [W-1:0] line_out  // Driven logic lines
);
	logic [15:0] left; // High cycles still to run

	// Raise the masked lines, hold them, then return them low
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			left     <= 16'h0;
			line_out <= '0;
		end else if (go_in) begin
			left     <= len_in;
			line_out <= mask_in;
		end else if (left > 16'h1) begin
			left <= left - 16'h1;
		end else begin
			left     <= 16'h0;
			line_out <= '0; // Every pulse ends low
		end
	end

	// Busy while any line is held
	assign busy_out = (left != 16'h0);
endmodule
`default_nettype wire

// [bench/tlos_top_props.sv]
// Concurrent checks on the operator set ports
`timescale 1ns/100ps
`default_nettype none
module tlos_top_props #(
	parameter int TICK_CYCLES = 10 // Clocks per ms tick
) (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic        ce_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic [7:0]  filter_in,
	input wire logic [7:0]  filter_out,
	input wire logic [7:0]  all_in,
	input wire logic [7:0]  all_out,
	input wire logic [7:0]  glob_in,
	input wire logic        glob_toggle_in,
	input wire logic [7:0]  glob_out,
	input wire logic        sc_set_in,
	input wire logic        sc_clear_in,
	input wire logic [7:0]  sc_out,
	input wire logic [7:0]  split_in,
	input wire logic [15:0] split_out
);
	logic [15:0] exp_split; // Expected splitter pattern
	logic [1:0]  mode_q;    // Last written mode

	// Splitter pattern worked out from the inputs
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			exp_split[2*i]   = split_in[i];
			exp_split[2*i+1] = ~split_in[i];
		end
	end

	// Shadow of the mode register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_q <= tlos_pkg::MODE_RESET;
		end else if (ce_in && reg_wr_in && reg_addr_in == tlos_pkg::REG_MODE) begin
			mode_q <= reg_wdata_in[1:0];
		end
	end

	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// Completed pulses, clock enabled at both edges of the fall
	sequence s_set_done;
		ce_in && $past(ce_in) && $fell(sc_set_in) && !sc_clear_in && !$past(sc_clear_in);
	endsequence
	sequence s_clr_done;
		ce_in && $past(ce_in) && $fell(sc_clear_in);
	endsequence
	sequence s_all_done;
		ce_in && $past(ce_in) && |(~all_in & $past(all_in));
	endsequence

	AST_SPLIT: assert property (
		$past(reset_n_in) && $past(ce_in) |-> split_out == $past(exp_split))
		else $error("splitter outputs wrong");
	AST_SET: assert property (s_set_done |-> ##[1:2] sc_out == 8'hff)
		else $error("global set did not raise all");
	AST_CLEAR: assert property (s_clr_done |-> ##[1:2] sc_out == 8'h00)
		else $error("global clear did not lower all");
	AST_ALL_FORM: assert property (all_out == 8'h00 || all_out == 8'hff)
		else $error("latch-all outputs disagree");
	AST_ALL_TOG: assert property (s_all_done |-> ##[1:2] $changed(all_out))
		else $error("latch-all did not toggle");
	AST_GLOB: assert property (
		ce_in && $past(ce_in) && $fell(glob_toggle_in) && glob_out != 8'hff && glob_in == 8'h00
		|-> ##[1:2] glob_out == 8'hff)
		else $error("global toggle did not raise lows");
	AST_FILTER: assert property (
		((filter_out ^ $past(filter_out)) & (filter_out ^ $past(filter_in))) == 8'h00)
		else $error("filter output moved against input");
	AST_MODE_RD: assert property (
		ce_in && reg_rd_in && reg_addr_in == tlos_pkg::REG_MODE
		|=> reg_rdata_out == {30'h0, mode_q})
		else $error("mode readback wrong");
endmodule
bind tlos_top tlos_top_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.*);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the timed logic operator set
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	logic        clk_in = 1'b0;       // System clock
	logic        reset_n_in = 1'b0;   // Async reset
	logic [7:0]  reg_addr_in = 8'h0;  // Bus address
	logic [31:0] reg_wdata_in = 32'h0; // Bus write data
	logic        reg_wr_in = 1'b0;    // Write strobe
	logic        reg_rd_in = 1'b0;    // Read strobe
	logic        ce_in = 1'b1;        // Clock enable
	logic [31:0] reg_rdata_out, d;    // Read data
	logic [7:0]  pulse_out, filter_out, all_out, glob_out, sc_out, split_in = 8'ha5;
	logic [15:0] split_out, e16;      // Splitter outputs
	logic [42:0] line, mask = '0;     // Source lines
	logic [15:0] len = 16'h0;         // Source high time
	logic        go = 1'b0, busy;     // Source handshake
	int          mismatches = 0, cmp_count = 0, cyc = 0, r;

	// Clock source
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	tlos_top #(.TICK_CYCLES(10)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pulse_in(line[7:0]),
		.pulse_out(pulse_out), .filter_in(line[15:8]), .filter_out(filter_out),
		.all_in(line[23:16]), .all_out(all_out), .glob_in(line[31:24]),
		.glob_toggle_in(line[40]), .glob_out(glob_out), .sc_in(line[39:32]),
		.sc_set_in(line[41]), .sc_clear_in(line[42]), .sc_out(sc_out),
		.split_in(split_in), .split_out(split_out));
	tlos_logic_src #(.W(43)) i_src (.clk_in(clk_in), .reset_n_in(reset_n_in), .go_in(go),
		.mask_in(mask), .len_in(len), .busy_out(busy), .line_out(line));

	// Verdict and end of run
	task automatic close_out();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= v;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	// Start a source pulse on one line
	task automatic src_go(input int b, input int n);
		@(posedge clk_in);
		mask <= 43'h1 << b;
		len  <= n[15:0];
		go   <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		#1;
	endtask
	// Wait for the line to drop, then settle
	task automatic src_end();
		while (busy) @(posedge clk_in);
		repeat (6) @(posedge clk_in);
		#1;
	endtask
	task automatic pls(input int b);
		src_go(b, 2);
		src_end();
	endtask
	// Count rises of one pulse output
	task automatic rises(input int n, input int b, output int c);
		logic p;
		c = 0;
		p = pulse_out[b];
		repeat (n) begin
			@(posedge clk_in);
			#1;
			if (pulse_out[b] && !p) c++;
			p = pulse_out[b];
		end
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		`CHK({sc_out, glob_out, all_out, pulse_out}, 32'h0)
		reset_n_in <= 1'b1;
		wr(tlos_pkg::REG_PULSE_ON, 32'h2000);
		rd(tlos_pkg::REG_PULSE_ON, d);
		`CHK(d, 32'h1770)
		rd(8'h40, d);
		`CHK(d, 32'h0)
		wr(tlos_pkg::REG_PULSE_ON, 32'h0);
		wr(tlos_pkg::REG_PULSE_OFF, 32'h0);
		src_go(3, 2);
		rises(12, 3, r);
		`CHK(r, 1)
		wr(tlos_pkg::REG_PULSE_ON, 32'h2);
		wr(tlos_pkg::REG_PULSE_OFF, 32'h2);
		src_go(0, 3);
		rises(150, 0, r);
		`CHK(r, 1)
		src_go(1, 200);
		rises(300, 1, r);
		`CHK(r >= 3, 1'b1)
		`CHK(pulse_out, 8'h00)
		wr(tlos_pkg::REG_MODE, 32'h1);
		rd(tlos_pkg::REG_MODE, d);
		`CHK(d, 32'h1)
		src_go(2, 200);
		rises(300, 2, r);
		`CHK(r, 1)
		wr(tlos_pkg::REG_MODE, 32'h2);
		rises(200, 7, r);
		`CHK(r >= 3, 1'b1)
		wr(tlos_pkg::REG_MODE, 32'h0);
		repeat (100) @(posedge clk_in);
		`CHK(pulse_out, 8'h00)
		wr(tlos_pkg::REG_DEB_ON, 32'h3);
		wr(tlos_pkg::REG_DEB_OFF, 32'h1);
		src_go(10, 60);
		repeat (15) @(posedge clk_in);
		`CHK(filter_out, 8'h00)
		repeat (30) @(posedge clk_in);
		`CHK(filter_out, 8'h04)
		src_end();
		repeat (30) @(posedge clk_in);
		`CHK(filter_out, 8'h00)
		src_go(10, 10);
		src_end();
		repeat (50) @(posedge clk_in);
		`CHK(filter_out, 8'h00)
		pls(19);
		`CHK(all_out, 8'hff)
		pls(16);
		`CHK(all_out, 8'h00)
		pls(25);
		`CHK(glob_out, 8'h02)
		pls(40);
		`CHK(glob_out, 8'hff)
		pls(40);
		`CHK(glob_out, 8'h02)
		rd(tlos_pkg::REG_STATE_A, d);
		`CHK(d, 32'h2 << tlos_pkg::STA_GLOB_LSB)
		@(posedge clk_in);
		#1;
		`CHK(reg_rdata_out, 32'h0)
		// Enable low: a write and a pulse must both be lost
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(tlos_pkg::REG_MODE, 32'h2);
		pls(16);
		@(posedge clk_in);
		ce_in <= 1'b1;
		#1;
		`CHK(all_out, 8'h00)
		rd(tlos_pkg::REG_MODE, d);
		`CHK(d, 32'h0)
		pls(36);
		`CHK(sc_out, 8'h10)
		pls(41);
		`CHK(sc_out, 8'hff)
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_in);
			split_in <= (k == 0) ? 8'ha5 : 8'h3c;
			repeat (2) @(posedge clk_in);
			#1;
			for (int i = 0; i < 8; i++) begin
				e16[2*i]   = split_in[i];
				e16[2*i+1] = ~split_in[i];
			end
			`CHK(split_out, e16)
		end
		rd(tlos_pkg::REG_STATE_B, d);
		`CHK(d, {e16, 8'h00, 8'hff})
		pls(42);
		`CHK(sc_out, 8'h00)
		pls(41);
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		`CHK({split_out, filter_out, sc_out, glob_out, all_out, pulse_out}, 56'h0)
		reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		`CHK(split_out, e16)
		close_out();
	end
endmodule
`undef CHK
`default_nettype wire
